// file: design/tlcs_pkg.sv
`default_nettype none
package tlcs_pkg;
  // **********************************************************************
  // Widths and word layout
  // **********************************************************************
  localparam int WORD_W         = 64;
  localparam int CAL_ENTRIES    = 256;
  localparam int CAL_GROUP      = 16;
  localparam int CAL_GRP_W      = 4;
  localparam int MU_W           = 8;
  localparam int TOKEN_W        = 12;
  localparam int PERIOD_W       = 8;
  localparam int BYTES_W        = 4;
  localparam int LANES          = 12;
  localparam int CW_CAL_START   = 56;
  localparam int CW_CAL_HI      = 55;
  localparam int CW_CAL_LO      = 40;
  localparam int CW_MU_HI       = 31;
  localparam int CW_MU_LO       = 24;
  localparam int DIAG_LANE_BIT  = 33;
  localparam int DIAG_INTF_BIT  = 32;
  localparam int SYNC_STAGES    = 2;

  // **********************************************************************
  // Values after reset
  // **********************************************************************
  localparam logic [TOKEN_W-1:0]   TOKENS_RST   = 12'h000;
  localparam logic [PERIOD_W-1:0]  REFILL_RST   = 8'h00;
  localparam logic [CAL_GRP_W-1:0] CAL_GRP_RST  = 4'h0;
  localparam logic [WORD_W-1:0]    WORD_RST     = 64'h0000000000000000;

  // **********************************************************************
  // Carriers
  // **********************************************************************
  // Rate limiter configuration from user logic.
  typedef struct packed {
    logic                on;
    logic [TOKEN_W-1:0]  capacity;
    logic [TOKEN_W-1:0]  refill_amount;
    logic [PERIOD_W-1:0] refill_period;
  } tlcs_shaper_cfg_type;

  // Diagnostic word status of one lane: bit 33 and bit 32.
  typedef struct packed {
    logic lane_health;
    logic intf_health;
  } tlcs_diag_type;

  // Whole state of the main module.
  typedef struct packed {
    logic [WORD_W-1:0]    word;
    logic                 word_valid;
    logic                 word_ctrl;
    logic [CAL_GRP_W-1:0] cal_group;
    logic [TOKEN_W-1:0]   tokens;
    logic [PERIOD_W-1:0]  refill_cnt;
    logic                 link_xoff;
    logic                 starved;
    logic                 overrun;
  } tlcs_state_type;
endpackage : tlcs_pkg
`default_nettype wire

// file: design/tlcs_sync.sv
`timescale 1ns/1ps
`default_nettype none
module tlcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock, reset and enable.
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic             ce_in,
  // Asynchronous bits in, synchronous bits out.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import tlcs_pkg::*;

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } tlcs_sync_state_type;

  tlcs_sync_state_type state_reg;
  tlcs_sync_state_type state_next;

  // **********************************************************************
  // Two flip-flops per bit
  // **********************************************************************
  // Only the second stage reads the first one.
  genvar b;
  for (b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      state_next.meta[b]   = async_in[b];
      state_next.stable[b] = state_reg.meta[b];
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg <= '0;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sync_delay_a: assert property (ce_in [*3] |-> sync_out == $past(async_in, 2))
    else $error("synchroniser output is not the input two cycles back");
endmodule : tlcs_sync
`default_nettype wire

// file: design/tlcs_top.sv
`timescale 1ns/1ps
`default_nettype none
module tlcs_top (
  // Clock, reset and enable.
  input  wire logic                            clk_in,
  input  wire logic                            sys_rst_in,
  input  wire logic                            ce_in,
  // Link controls.
  input  wire logic                            tx_permit_in,
  input  wire logic [tlcs_pkg::CAL_ENTRIES-1:0] tx_flow_calendar_status_in,
  input  wire logic [tlcs_pkg::MU_W-1:0]       tx_multi_use_field_in,
  input  wire tlcs_pkg::tlcs_shaper_cfg_type   shaper_cfg_in,
  // Asynchronous health inputs.
  input  wire logic [tlcs_pkg::LANES-1:0]      tx_lane_health_bits_in,
  input  wire logic                            tx_interface_health_bit_in,
  // Packet data from user logic.
  input  wire logic                            data_valid_in,
  input  wire logic [tlcs_pkg::WORD_W-1:0]     data_word_in,
  input  wire logic [tlcs_pkg::BYTES_W-1:0]    data_bytes_in,
  output logic                                 data_ready_out,
  // Word stream to the lane striper.
  input  wire logic                            link_take_in,
  output logic                                 link_word_valid_out,
  output logic                                 link_word_ctrl_out,
  output logic [tlcs_pkg::WORD_W-1:0]          link_word_out,
  // Diagnostic word status per lane.
  output tlcs_pkg::tlcs_diag_type [tlcs_pkg::LANES-1:0] diag_status_out,
  // Status flags.
  output logic                                 link_xoff_out,
  output logic                                 starved_out,
  output logic                                 overrun_out
);
  import tlcs_pkg::*;

  tlcs_state_type            state_reg;
  tlcs_state_type            state_next;
  logic [CAL_GROUP-1:0]      cal_slice;
  logic [WORD_W-1:0]         ctrl_word;
  logic [LANES:0]            health_sync;
  logic                      slot_free;
  logic                      token_ok;
  logic                      data_go;
  logic                      refill_evt;
  logic [TOKEN_W+1:0]        token_sum;
  logic [PERIOD_W-1:0]       cnt_inc;

  // **********************************************************************
  // Health synchronisers and diagnostic bits
  // **********************************************************************
  tlcs_sync #(
    .WIDTH (LANES + 1)
  ) u_health_sync (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .ce_in      (ce_in),
    .async_in   ({tx_interface_health_bit_in, tx_lane_health_bits_in}),
    .sync_out   (health_sync)
  );

  // Each lane carries its own bit 33 and the shared bit 32.
  genvar ln;
  for (ln = 0; ln < LANES; ln++) begin : g_lane
    assign diag_status_out[ln].lane_health = health_sync[ln];
    assign diag_status_out[ln].intf_health = health_sync[LANES];
  end

  // **********************************************************************
  // Calendar group and control word
  // **********************************************************************
  // Entry 16*group+k lands on word bit 55-k.
  genvar k;
  for (k = 0; k < CAL_GROUP; k++) begin : g_cal
    assign cal_slice[CAL_GROUP-1-k] =
      tx_flow_calendar_status_in[{state_reg.cal_group, 4'(k)}];
  end

  // Idle control word with calendar group and multi-use field.
  always_comb begin
    ctrl_word                        = WORD_RST;
    ctrl_word[CW_CAL_START]          = (state_reg.cal_group == CAL_GRP_RST);
    ctrl_word[CW_CAL_HI:CW_CAL_LO]   = cal_slice;
    ctrl_word[CW_MU_HI:CW_MU_LO]     = tx_multi_use_field_in;
  end

  // **********************************************************************
  // Handshake and token bucket
  // **********************************************************************
  // The output slot is free when empty or being taken this cycle.
  assign slot_free      = !state_reg.word_valid || link_take_in;
  assign token_ok       = !shaper_cfg_in.on || ({8'h00, data_bytes_in} <= state_reg.tokens);
  assign data_ready_out = tx_permit_in && token_ok && slot_free;
  assign data_go        = data_ready_out && data_valid_in && ce_in;
  assign cnt_inc        = state_reg.refill_cnt + 8'h01;
  assign refill_evt     = (cnt_inc >= shaper_cfg_in.refill_period);
  // Tokens after spending and refilling, before the cap is applied.
  assign token_sum = {2'b00, state_reg.tokens}
                   - ((data_go && shaper_cfg_in.on) ? {10'h000, data_bytes_in} : 14'h0000)
                   + (refill_evt ? {2'b00, shaper_cfg_in.refill_amount} : 14'h0000);

  // **********************************************************************
  // Next state
  // **********************************************************************
  always_comb begin
    state_next            = state_reg;
    state_next.link_xoff  = !tx_permit_in;
    state_next.refill_cnt = refill_evt ? REFILL_RST : cnt_inc;
    // Saturate the bucket at the configured capacity.
    if (token_sum > {2'b00, shaper_cfg_in.capacity}) begin
      state_next.tokens = shaper_cfg_in.capacity;
    end else begin
      state_next.tokens = token_sum[TOKEN_W-1:0];
    end
    if (link_take_in) begin
      state_next.word_valid = 1'b0;
    end
    // Load the output slot: data if allowed, else an idle control word.
    if (slot_free) begin
      state_next.word_valid = 1'b1;
      if (data_go) begin
        state_next.word      = data_word_in;
        state_next.word_ctrl = 1'b0;
      end else begin
        state_next.word      = ctrl_word;
        state_next.word_ctrl = 1'b1;
        state_next.cal_group = state_reg.cal_group + 4'h1;
      end
    end
    // The link asked for a word that was not there.
    if (link_take_in && !state_reg.word_valid) begin
      state_next.starved = 1'b1;
    end
    // Data accepted (valid and ready) while the slot is occupied means the handshake broke.
    if (data_valid_in && data_ready_out && !slot_free) begin
      state_next.overrun = 1'b1;
    end
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state_reg            <= '0;
      state_reg.tokens     <= TOKENS_RST;
      state_reg.refill_cnt <= REFILL_RST;
      state_reg.cal_group  <= CAL_GRP_RST;
      state_reg.link_xoff  <= 1'b1;
    end else if (ce_in) begin
      state_reg <= state_next;
    end
  end

  // Outputs come straight from the state register.
  assign link_word_valid_out = state_reg.word_valid;
  assign link_word_ctrl_out  = state_reg.word_ctrl;
  assign link_word_out       = state_reg.word;
  assign link_xoff_out       = state_reg.link_xoff;
  assign starved_out         = state_reg.starved;
  assign overrun_out         = state_reg.overrun;

  // **********************************************************************
  // Checks
  // **********************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  sequence load_ctrl_s;
    ce_in && slot_free && !data_go;
  endsequence

  permit_gate_a: assert property (!tx_permit_in |-> !data_ready_out)
    else $error("data accepted while permit is low");
  xoff_state_a: assert property (ce_in && !tx_permit_in |=> link_xoff_out)
    else $error("link not in xoff after permit low");
  cal_start_a: assert property (load_ctrl_s |=>
      link_word_out[CW_CAL_START] == ($past(state_reg.cal_group) == 4'h0))
    else $error("calendar start bit wrong");
  cal_order_a: assert property (load_ctrl_s |=>
      link_word_out[CW_CAL_HI] == $past(tx_flow_calendar_status_in[{state_reg.cal_group, 4'h0}])
      && link_word_out[CW_CAL_LO] ==
         $past(tx_flow_calendar_status_in[{state_reg.cal_group, 4'hF}]))
    else $error("calendar bit order wrong");
  cal_next_a: assert property (load_ctrl_s |=>
      state_reg.cal_group == $past(state_reg.cal_group) + 4'h1)
    else $error("calendar group did not advance");
  mu_field_a: assert property (load_ctrl_s |=>
      link_word_out[CW_MU_HI:CW_MU_LO] == $past(tx_multi_use_field_in))
    else $error("multi-use field not carried");
  shaper_bypass_a: assert property (!shaper_cfg_in.on && tx_permit_in && slot_free
      |-> data_ready_out)
    else $error("data held back with shaper off");
  bucket_cap_a: assert property (ce_in |=> state_reg.tokens <= $past(shaper_cfg_in.capacity))
    else $error("bucket above capacity");
  refill_add_a: assert property (ce_in && refill_evt && !data_go
      && token_sum <= {2'b00, shaper_cfg_in.capacity}
      |=> state_reg.tokens == $past(state_reg.tokens) + $past(shaper_cfg_in.refill_amount))
    else $error("refill amount not added");
  refill_space_a: assert property (ce_in && refill_evt |=> state_reg.refill_cnt == 8'h00)
    else $error("refill counter did not restart");
  token_hold_a: assert property (shaper_cfg_in.on && data_ready_out
      |-> {8'h00, data_bytes_in} <= state_reg.tokens)
    else $error("data sent without enough tokens");
  starve_flag_a: assert property (ce_in && link_take_in && !link_word_valid_out
      |=> starved_out [*2])
    else $error("starvation not flagged");
  overrun_hold_a: assert property (overrun_out |=> overrun_out)
    else $error("overrun flag dropped without reset");
  overrun_cause_a: assert property (!overrun_out
      && !(data_valid_in && data_ready_out && !slot_free) |=> !overrun_out)
    else $error("overrun flag raised without a failure");

  data_sent_c: cover property (data_go ##1 link_word_valid_out && !link_word_ctrl_out);
  cal_wrap_c: cover property (load_ctrl_s and state_reg.cal_group == 4'hF);
  shaper_stall_c: cover property (shaper_cfg_in.on && tx_permit_in && slot_free && !token_ok);
  starve_c: cover property (link_take_in && !link_word_valid_out);
endmodule : tlcs_top
`default_nettype wire

// file: dv/tlcs_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************************************************
// Far-side word consumer
// ********************************************************************
module tlcs_far_model (
  // Clock and pace.
  input  wire logic       clk_in,
  input  wire logic [1:0] mode_in,
  // Word stream handshake.
  output logic            link_take_out
);
  // Mode 0 stalls, 1 takes every cycle, 2 takes every other cycle.
  initial link_take_out = 1'b0;
  always @(posedge clk_in) begin
    link_take_out <= (mode_in == 2'h1) || ((mode_in == 2'h2) && !link_take_out);
  end
endmodule // tlcs_far_model
`default_nettype wire

// file: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import tlcs_pkg::*;
  // ******************************************************************
  // Signals
  // ******************************************************************
  logic                      clk    = 1'b0;
  logic                      rst    = 1'b1;
  logic                      ce     = 1'b1;
  logic                      permit = 1'b0;
  logic [CAL_ENTRIES-1:0]    cal    = '0;
  logic [MU_W-1:0]           mu     = 8'h00;
  tlcs_shaper_cfg_type       cfg    = '{1'b0, 12'h008, 12'h003, 8'h04};
  logic [LANES-1:0]          lanes  = 12'h000;
  logic                      intf   = 1'b0;
  logic                      dvalid = 1'b0;
  logic [WORD_W-1:0]         dword  = '0;
  logic [BYTES_W-1:0]        dbytes = 4'h0;
  logic [1:0]                mode   = 2'h0;
  logic                      ready, take, wvalid, wctrl, xoff, starved, overrun;
  logic [WORD_W-1:0]         wword;
  tlcs_diag_type [LANES-1:0] diag;
  logic [64:0]               r, expw;
  int                        fail_count = 0;
  int                        checks = 0;
  int                        cycles = 0;
  int                        n;

  tlcs_top u_tlcs_top (.clk_in(clk), .sys_rst_in(rst), .ce_in(ce), .tx_permit_in(permit),
    .tx_flow_calendar_status_in(cal), .tx_multi_use_field_in(mu), .shaper_cfg_in(cfg),
    .tx_lane_health_bits_in(lanes), .tx_interface_health_bit_in(intf),
    .data_valid_in(dvalid), .data_word_in(dword), .data_bytes_in(dbytes),
    .data_ready_out(ready), .link_take_in(take), .link_word_valid_out(wvalid),
    .link_word_ctrl_out(wctrl), .link_word_out(wword), .diag_status_out(diag),
    .link_xoff_out(xoff), .starved_out(starved), .overrun_out(overrun));
  tlcs_far_model u_tlcs_far_model (.clk_in(clk), .mode_in(mode), .link_take_out(take));

  // Clock and a cycle ceiling that cuts a hang short.
  always #50 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  // ******************************************************************
  // Tasks
  // ******************************************************************
  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk_word(input logic [64:0] got, input logic [64:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t word %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t bit %b expected %b", $time, got, exp);
    end
  endtask

  // Waits at falling edges for a word that the far side takes, then steps on.
  task automatic get_word(output logic [64:0] w);
    int k;
    k = 0;
    while (!(wvalid === 1'b1 && take === 1'b1) && k < 50) begin
      @(negedge clk);
      k++;
    end
    chk_bit(k < 50, 1'b1);
    w = {wctrl, wword};
    @(negedge clk);
  endtask

  // Offers one word until ready or the limit; k is the wait in cycles.
  task automatic send(input logic [63:0] d, input logic [3:0] b, input int lim, output int k);
    @(negedge clk);
    dword = d;
    dbytes = b;
    dvalid = 1'b1;
    k = 0;
    #10;
    while (ready !== 1'b1 && k < lim) begin
      @(negedge clk);
      #10;
      k++;
    end
    @(negedge clk);
    dvalid = 1'b0;
  endtask

  task automatic send_chk(input logic [63:0] d, input logic [3:0] b, output int k);
    int m;
    send(d, b, 40, k);
    m = 0;
    get_word(r);
    while (r[64] !== 1'b0 && m < 4) begin
      get_word(r);
      m++;
    end
    chk_word(r, {1'b0, d});
  endtask

  // ******************************************************************
  // Main sequence
  // ******************************************************************
  initial begin
    for (int i = 0; i < CAL_ENTRIES; i++) cal[i] = ((i * 7) % 5) < 2;
    repeat (6) @(negedge clk);
    chk_bit(xoff, 1'b1);
    rst = 1'b0;
    mode = 2'h2;
    mu = 8'hA5;
    dvalid = 1'b1;
    dbytes = 4'h1;
    repeat (2) @(negedge clk);
    n = 0;
    get_word(r);
    while (r[56] !== 1'b1 && n < 20) begin
      get_word(r);
      n++;
    end
    for (int g = 0; g < 17; g++) begin
      expw = '0;
      expw[64] = 1'b1;
      expw[56] = (g % 16) == 0;
      for (int k = 0; k < CAL_GROUP; k++) expw[55-k] = cal[16*(g%16)+k];
      expw[31:24] = mu;
      chk_word(r, expw);
      chk_bit(ready, 1'b0);
      get_word(r);
    end
    chk_bit(xoff, 1'b1);
    dvalid = 1'b0;
    mu = 8'h00;
    permit = 1'b1;
    mode = 2'h1;
    repeat (3) @(negedge clk);
    chk_bit(xoff, 1'b0);
    send_chk(64'h0123456789ABCDEF, 4'hF, n);
    chk_bit(n <= 2, 1'b1);
    mode = 2'h0;
    send(64'h2222222222222222, 4'h1, 6, n);
    chk_bit(n == 6, 1'b1);
    mode = 2'h1;
    cfg.on = 1'b1;
    repeat (2) @(negedge clk);
    send_chk(64'hFEDCBA9876543210, 4'h8, n);
    chk_bit(n <= 2, 1'b1);
    send_chk(64'h0F1E2D3C4B5A6978, 4'h8, n);
    chk_bit(n >= 4 && n <= 13, 1'b1);
    send(64'h1111111111111111, 4'h9, 40, n);
    chk_bit(n == 40, 1'b1);
    lanes = 12'hA5C;
    intf = 1'b1;
    @(negedge clk);
    chk_bit(diag[2].lane_health, 1'b0);
    repeat (2) @(negedge clk);
    for (int l = 0; l < LANES; l++) begin
      chk_bit(diag[l].lane_health, lanes[l]);
      chk_bit(diag[l].intf_health, 1'b1);
    end
    // With the clock enable low, status and synchronisers must hold still.
    ce = 1'b0;
    lanes = 12'h000;
    permit = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(diag[2].lane_health, 1'b1);
    chk_bit(xoff, 1'b0);
    permit = 1'b1;
    ce = 1'b1;
    repeat (3) @(negedge clk);
    chk_bit(diag[2].lane_health, 1'b0);
    chk_bit(starved, 1'b0);
    chk_bit(overrun, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit(starved, 1'b1);
    chk_bit(overrun, 1'b0);
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
